/* File: rtl/positive_input_pin_ctl.sv */
// What this block does
// [R1] Bit 7 enable turns comparator function on when one, off when zero.
// [R2] Bit 6 selects positive pin when zero, internal bandgap when one.
// [R3] Bit 5 flag sets on selected event, cleared only by writing one.
// [R4] With bit 4 set and mask register bit 0 set, interrupt requested while flag set; else never.
// [R5] Bit 3 reads live result; zero at reset and while disabled.
// [R6] Bit 2 plus enable drives result onto output pin; otherwise no control.
// [R7] Mode bits 1:0: 00 and 10 falling, 01 rising, 11 either edge.
// [R8] Logic keeps running in wait; interrupt can wake processor.
// [R9] In stop, comparing, pin drive, flag and wake all continue.
// [R10] Reset leaving stop returns every control and status bit to reset.
// [R11] Background debug mode never suspends detection or flag setting.
// [R12] Control and status sit in one 8-bit register; the interrupt mask bit sits in a second register.
// [R13] Software should disable comparator before wait if not a wake source.
// [R14] Result high when non-inverting input above inverting, low when below.
// [R15] Raw result passes two flip-flops before edge detection.
// [R16] Writing zero leaves flag; event coinciding with clear keeps it set.
`timescale 1ns/10ps
`default_nettype none
`include "positive_input_pin_ctl_params.svh"
module positive_input_pin_ctl
    import positive_input_pin_ctl_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // Register port
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Analog core
    input wire logic i_core_result,
    output logic o_core_enable,
    output logic o_reference_select,
    // Power modes
    input wire logic i_wait_mode,
    input wire logic i_stop_mode,
    input wire logic i_debug_mode,
    // Pin and interrupt
    output logic o_compare_out_pin,
    output logic o_compare_out_pin_oe_n,
    output logic o_irq
);
    // ****************************************
    // Registers
    // ****************************************
    logic compare_enable_q;
    logic reference_select_q;
    logic compare_event_flag_q;
    logic compare_irq_enable_q;
    logic output_pin_enable_q;
    positive_input_pin_edge_type event_edge_mode_q;
    logic irq_mask_q;
    logic [7:0] rdata_q;
    logic result_sync;
    logic result_prev_q;
    logic rise;
    logic fall;
    logic event_hit;
    logic wr_sc;
    logic wr_mask;
    logic [7:0] sc_view;
    logic compare_result_level;

    assign wr_sc = i_wr && (i_addr == `POSITIVE_INPUT_PIN_OFS_SC);
    assign wr_mask = i_wr && (i_addr == `POSITIVE_INPUT_PIN_OFS_IMASK);

    // ****************************************
    // Control fields
    // ****************************************
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin // [R10]
            compare_enable_q <= 1'b0;
            reference_select_q <= 1'b0;
            compare_irq_enable_q <= 1'b0;
            output_pin_enable_q <= 1'b0;
            event_edge_mode_q <= POSITIVE_INPUT_PIN_EDGE_FALL_A;
        end else if (wr_sc) begin
            compare_enable_q <= i_wdata[`POSITIVE_INPUT_PIN_BIT_ENABLE]; // [R1]
            reference_select_q <= i_wdata[`POSITIVE_INPUT_PIN_BIT_REFSEL]; // [R2]
            compare_irq_enable_q <= i_wdata[`POSITIVE_INPUT_PIN_BIT_IRQEN]; // [R4]
            output_pin_enable_q <= i_wdata[`POSITIVE_INPUT_PIN_BIT_PINEN]; // [R6]
            event_edge_mode_q <= positive_input_pin_edge_type'(i_wdata[`POSITIVE_INPUT_PIN_BIT_MODE_HI:`POSITIVE_INPUT_PIN_BIT_MODE_LO]); // [R7]
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            irq_mask_q <= 1'b1;
        end else if (wr_mask) begin
            irq_mask_q <= i_wdata[0];
        end
    end

    // ****************************************
    // Result sync and edge detect
    // ****************************************
    positive_input_pin_sync u_sync (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_async(i_core_result), // [R14]
        .o_sync(result_sync) // [R15]
    );

    assign compare_result_level = compare_enable_q & result_sync; // [R5]

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            result_prev_q <= 1'b0;
        end else begin
            result_prev_q <= compare_result_level;
        end
    end

    assign rise = compare_result_level & ~result_prev_q;
    assign fall = ~compare_result_level & result_prev_q & compare_enable_q;

    always_comb begin
        case (event_edge_mode_q) // [R7]
            POSITIVE_INPUT_PIN_EDGE_FALL_A: event_hit = fall;
            POSITIVE_INPUT_PIN_EDGE_RISE: event_hit = rise;
            POSITIVE_INPUT_PIN_EDGE_FALL_B: event_hit = fall;
            POSITIVE_INPUT_PIN_EDGE_BOTH: event_hit = rise | fall;
            default: event_hit = 1'b0;
        endcase
    end

    // ****************************************
    // Event flag
    // ****************************************
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            compare_event_flag_q <= 1'b0;
        end else if (event_hit) begin
            compare_event_flag_q <= 1'b1; // [R3] [R16]
        end else if (wr_sc && i_wdata[`POSITIVE_INPUT_PIN_BIT_FLAG]) begin
            compare_event_flag_q <= 1'b0; // [R3]
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    assign sc_view = {compare_enable_q, reference_select_q, compare_event_flag_q, compare_irq_enable_q,
                      compare_result_level, output_pin_enable_q, event_edge_mode_q}; // [R12]

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rdata_q <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                `POSITIVE_INPUT_PIN_OFS_SC: rdata_q <= sc_view;
                `POSITIVE_INPUT_PIN_OFS_IMASK: rdata_q <= {7'h00, irq_mask_q};
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign o_rdata = rdata_q;
    assign o_core_enable = compare_enable_q; // [R1]
    assign o_reference_select = reference_select_q; // [R2]
    assign o_compare_out_pin = compare_enable_q & output_pin_enable_q & result_sync; // [R6] [R9]
    assign o_compare_out_pin_oe_n = ~(compare_enable_q & output_pin_enable_q); // [R6]
    assign o_irq = compare_irq_enable_q & irq_mask_q & compare_event_flag_q; // [R4] [R8]

    // ****************************************
    // Assertions
    // ****************************************
    property p_flag_sets_on_event;
        @(posedge i_ref_clk) disable iff (i_sys_rst) event_hit |=> compare_event_flag_q;
    endproperty
    a_flag_sets_on_event: assert property (p_flag_sets_on_event) else $error("flag not set on event"); // [R3]

    property p_flag_holds;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
            compare_event_flag_q && !(wr_sc && i_wdata[`POSITIVE_INPUT_PIN_BIT_FLAG]) |=> compare_event_flag_q;
    endproperty
    a_flag_holds: assert property (p_flag_holds) else $error("flag dropped without clear"); // [R16]

    property p_flag_clears;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
            wr_sc && i_wdata[`POSITIVE_INPUT_PIN_BIT_FLAG] && !event_hit |=> !compare_event_flag_q;
    endproperty
    a_flag_clears: assert property (p_flag_clears) else $error("flag not cleared"); // [R3]

    property p_irq_gate;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
            o_irq == (compare_irq_enable_q && irq_mask_q && compare_event_flag_q);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq mismatch"); // [R4]

    property p_result_off;
        @(posedge i_ref_clk) disable iff (i_sys_rst) !compare_enable_q |-> !sc_view[`POSITIVE_INPUT_PIN_BIT_RESULT];
    endproperty
    a_result_off: assert property (p_result_off) else $error("result visible while off"); // [R5]

    property p_pin_released;
        @(posedge i_ref_clk) disable iff (i_sys_rst) !compare_enable_q |-> o_compare_out_pin_oe_n;
    endproperty
    a_pin_released: assert property (p_pin_released) else $error("pin driven while off"); // [R6]

    property p_sync_delay;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
            compare_enable_q && $rose(i_core_result) ##1 compare_enable_q && i_core_result |=> result_sync;
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("sync latency wrong"); // [R15]

    property p_rise_mode;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
            event_edge_mode_q == POSITIVE_INPUT_PIN_EDGE_RISE && fall |-> !event_hit;
    endproperty
    a_rise_mode: assert property (p_rise_mode) else $error("falling edge hit in rise mode"); // [R7]

    property p_read_latency;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
            i_rd && i_addr == `POSITIVE_INPUT_PIN_OFS_SC |=> o_rdata == $past(sc_view);
    endproperty
    a_read_latency: assert property (p_read_latency) else $error("read data wrong"); // [R12]

    property p_wait_runs;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
            i_wait_mode && event_hit |=> compare_event_flag_q;
    endproperty
    a_wait_runs: assert property (p_wait_runs) else $error("detection stalled in wait"); // [R8]

    property p_wait_wake;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
            i_wait_mode && compare_irq_enable_q && irq_mask_q && compare_event_flag_q |-> o_irq;
    endproperty
    a_wait_wake: assert property (p_wait_wake) else $error("no wake request in wait"); // [R8]

    property p_stop_pin;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
            i_stop_mode && compare_enable_q && output_pin_enable_q |-> !o_compare_out_pin_oe_n && o_compare_out_pin == result_sync;
    endproperty
    a_stop_pin: assert property (p_stop_pin) else $error("pin not driven in stop"); // [R9]

    property p_debug_runs;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
            i_debug_mode && event_hit |=> compare_event_flag_q;
    endproperty
    a_debug_runs: assert property (p_debug_runs) else $error("detection stalled in debug"); // [R11]

    property p_irq_off;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
            !compare_irq_enable_q |-> !o_irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq raised while disabled"); // [R4]

    property p_enable_write;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
            wr_sc |=> o_core_enable == $past(i_wdata[`POSITIVE_INPUT_PIN_BIT_ENABLE]);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable not written"); // [R1]

    property p_refsel_write;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
            wr_sc |=> o_reference_select == $past(i_wdata[`POSITIVE_INPUT_PIN_BIT_REFSEL]);
    endproperty
    a_refsel_write: assert property (p_refsel_write) else $error("reference select not written"); // [R2]

    property p_mode_write;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
            wr_sc |=> event_edge_mode_q == $past(i_wdata[`POSITIVE_INPUT_PIN_BIT_MODE_HI:`POSITIVE_INPUT_PIN_BIT_MODE_LO]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("edge mode not written"); // [R7]

    property p_both_mode;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
            event_edge_mode_q == POSITIVE_INPUT_PIN_EDGE_BOTH && (rise || fall) |-> event_hit;
    endproperty
    a_both_mode: assert property (p_both_mode) else $error("edge missed in either mode"); // [R7]

    property p_rise_single;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
            rise |=> !rise;
    endproperty
    a_rise_single: assert property (p_rise_single) else $error("rising edge seen twice"); // [R15]

    property p_fall_single;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
            fall |=> !fall;
    endproperty
    a_fall_single: assert property (p_fall_single) else $error("falling edge seen twice"); // [R15]

    property p_pin_off;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
            !output_pin_enable_q |-> o_compare_out_pin_oe_n && !o_compare_out_pin;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("pin driven while pin enable clear"); // [R6]

    property p_rdata_idle;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
            !i_rd |=> o_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle"); // [R12]
endmodule
`default_nettype wire

/* File: rtl/positive_input_pin_ctl_params.svh */
`ifndef POSITIVE_INPUT_PIN_CTL_PARAMS_SVH
`define POSITIVE_INPUT_PIN_CTL_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define POSITIVE_INPUT_PIN_OFS_SC 4'h0
`define POSITIVE_INPUT_PIN_OFS_IMASK 4'h1

// ****************************************
// Field positions
// ****************************************
`define POSITIVE_INPUT_PIN_BIT_ENABLE 7
`define POSITIVE_INPUT_PIN_BIT_REFSEL 6
`define POSITIVE_INPUT_PIN_BIT_FLAG 5
`define POSITIVE_INPUT_PIN_BIT_IRQEN 4
`define POSITIVE_INPUT_PIN_BIT_RESULT 3
`define POSITIVE_INPUT_PIN_BIT_PINEN 2
`define POSITIVE_INPUT_PIN_BIT_MODE_HI 1
`define POSITIVE_INPUT_PIN_BIT_MODE_LO 0

// ****************************************
// Reset values
// ****************************************
`define POSITIVE_INPUT_PIN_SC_RESET 8'h00
`define POSITIVE_INPUT_PIN_IMASK_RESET 8'h01

`endif

/* File: rtl/positive_input_pin_ctl_pkg.sv */
package positive_input_pin_ctl_pkg;
    typedef enum logic [1:0] {
        POSITIVE_INPUT_PIN_EDGE_FALL_A,
        POSITIVE_INPUT_PIN_EDGE_RISE,
        POSITIVE_INPUT_PIN_EDGE_FALL_B,
        POSITIVE_INPUT_PIN_EDGE_BOTH
    } positive_input_pin_edge_type;
endpackage

/* File: rtl/positive_input_pin_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module positive_input_pin_sync (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // Async level in, synced level out
    input wire logic i_async,
    output logic o_sync
);
    logic meta_q;
    logic sync_q;

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule
`default_nettype wire

/* File: testbench/positive_input_pin_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
module positive_input_pin_core_model (
    // Core controls
    input wire logic i_enable,
    input wire logic i_ref_sel,
    // Analog levels in millivolts
    input wire logic [11:0] i_pos_mv,
    input wire logic [11:0] i_neg_mv,
    input wire logic [11:0] i_gap_mv,
    // Raw result
    output logic o_result
);
    logic [11:0] plus_mv;
    assign plus_mv = i_ref_sel ? i_gap_mv : i_pos_mv;
    assign o_result = i_enable && (plus_mv > i_neg_mv);
endmodule
`default_nettype wire

/* File: testbench/positive_input_pin_ctl_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "positive_input_pin_ctl_params.svh"
module positive_input_pin_ctl_tb import positive_input_pin_ctl_pkg::*;;
    logic clk = 0, rst = 1, wr = 0, rd = 0, res, cen, rsel, pin, oe_n, irq;
    logic md_wait = 0, md_stop = 0, md_dbg = 0, rise, fall;
    logic [3:0] addr = 0;
    logic [7:0] wdata = 0, rdata;
    logic [11:0] pos = 12'h064, neg = 12'h1f4, gap = 12'h4b0;
    int fail_count = 0, compares = 0;
    positive_input_pin_edge_type e;
    always #5 clk = ~clk;
    positive_input_pin_core_model i_core (.i_enable(cen), .i_ref_sel(rsel), .i_pos_mv(pos), .i_neg_mv(neg),
        .i_gap_mv(gap), .o_result(res));
    positive_input_pin_ctl i_dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_core_result(res), .o_core_enable(cen),
        .o_reference_select(rsel), .i_wait_mode(md_wait), .i_stop_mode(md_stop),
        .i_debug_mode(md_dbg), .o_compare_out_pin(pin), .o_compare_out_pin_oe_n(oe_n), .o_irq(irq));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic end_sim();
        if (fail_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t output %b expected %b", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk8(rdata, exp);
    endtask
    // ****************************************
    // Watchdog
    // ****************************************
    initial begin
        idle(20000);
        fail_count++;
        $display("ERROR %0t run did not finish", $time);
        end_sim();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        idle(20);
        rst <= 1'b0;
        rreg(`POSITIVE_INPUT_PIN_OFS_SC, 8'h00);
        rreg(`POSITIVE_INPUT_PIN_OFS_IMASK, 8'h01);
        rreg(4'h7, 8'h00);
        chk1(oe_n, 1'b1);
        wreg(`POSITIVE_INPUT_PIN_OFS_SC, 8'h91);
        idle(1);
        chk1(cen, 1'b1);
        chk1(irq, 1'b0);
        pos <= 12'h384;
        idle(6);
        rreg(`POSITIVE_INPUT_PIN_OFS_SC, 8'hb9);
        chk1(irq, 1'b1);
        wreg(`POSITIVE_INPUT_PIN_OFS_SC, 8'h91);
        rreg(`POSITIVE_INPUT_PIN_OFS_SC, 8'hb9);
        wreg(`POSITIVE_INPUT_PIN_OFS_IMASK, 8'h00);
        idle(1);
        chk1(irq, 1'b0);
        wreg(`POSITIVE_INPUT_PIN_OFS_IMASK, 8'h01);
        wreg(`POSITIVE_INPUT_PIN_OFS_SC, 8'h81);
        idle(1);
        chk1(irq, 1'b0);
        wreg(`POSITIVE_INPUT_PIN_OFS_SC, 8'ha1);
        rreg(`POSITIVE_INPUT_PIN_OFS_SC, 8'h89);
        for (int m = 0; m < 4; m++) begin
            e = positive_input_pin_edge_type'(m);
            rise = (e == POSITIVE_INPUT_PIN_EDGE_RISE) || (e == POSITIVE_INPUT_PIN_EDGE_BOTH);
            fall = (e != POSITIVE_INPUT_PIN_EDGE_RISE);
            pos <= 12'h064;
            idle(6);
            wreg(`POSITIVE_INPUT_PIN_OFS_SC, {6'b101000, m[1:0]});
            pos <= 12'h384;
            idle(6);
            rreg(`POSITIVE_INPUT_PIN_OFS_SC, {2'b10, rise, 3'b010, m[1:0]});
            wreg(`POSITIVE_INPUT_PIN_OFS_SC, {6'b101000, m[1:0]});
            pos <= 12'h064;
            idle(6);
            rreg(`POSITIVE_INPUT_PIN_OFS_SC, {2'b10, fall, 3'b000, m[1:0]});
        end
        pos <= 12'h384;
        idle(1);
        wreg(`POSITIVE_INPUT_PIN_OFS_SC, 8'ha3);
        rreg(`POSITIVE_INPUT_PIN_OFS_SC, 8'hab);
        wreg(`POSITIVE_INPUT_PIN_OFS_SC, 8'he4);
        idle(6);
        chk1(rsel, 1'b1);
        chk1(pin, 1'b1);
        chk1(oe_n, 1'b0);
        rreg(`POSITIVE_INPUT_PIN_OFS_SC, 8'hcc);
        wreg(`POSITIVE_INPUT_PIN_OFS_SC, 8'h44);
        idle(1);
        chk1(oe_n, 1'b1);
        chk1(pin, 1'b0);
        chk1(cen, 1'b0);
        rreg(`POSITIVE_INPUT_PIN_OFS_SC, 8'h44);
        md_wait <= 1'b1;
        md_stop <= 1'b1;
        md_dbg <= 1'b1;
        wreg(`POSITIVE_INPUT_PIN_OFS_SC, 8'hb5);
        pos <= 12'h384;
        idle(6);
        chk1(irq, 1'b1);
        chk1(pin, 1'b1);
        chk1(oe_n, 1'b0);
        rst <= 1'b1;
        idle(2);
        rst <= 1'b0;
        rreg(`POSITIVE_INPUT_PIN_OFS_SC, 8'h00);
        rreg(`POSITIVE_INPUT_PIN_OFS_IMASK, 8'h01);
        chk1(irq, 1'b0);
        chk1(oe_n, 1'b1);
        end_sim();
    end
endmodule
`default_nettype wire
